// ===== hdl/module_reset_after_reconfig.sv
// reset sequencer inside a swappable module after partial reconfiguration
// Functional notes
// R1 - shell raises load_in_progress as soon as a module load is requested
// R2 - load_in_progress stays high at least until startup_done is seen; shell_model lifts its load reset one cycle after load_req falls
// R3 - external option: module reset is system reset OR load_in_progress
// R4 - combined reset may be registered for timing
// R5 - reset logic follows the polarity of each reset signal
// R6 - shell decoupler drives active reset level while loading
// R7 - reset held in await-startup state, released only when running
// R8 - return to await-startup comes from flip-flop reset only
// R9 - react to startup_done only after own load or system reset
// R10 - startup_done high during system reset is ignored until rearmed
// R11 - internal reset state is a single flip-flop
// R12 - non-resettable contents get rewritten on reset release
// R13 - reset spans configuration write release until after startup_done
// R14 - edge-reset block isolated until it has seen its reset edge
// R15 - dedicated edge reset pulse ends with level reset release
// R16 - single-reset alternative: pulse module reset after startup_done
// R17 - blocks without reset get clock enable only after startup_done
// R18 - reset-less blocks have inputs forced safe and outputs blocked
// R19 - shell blocks spurious module bus requests until safe
// R20 - each region gets its own module reset
// R21 - nothing enabled nor decoupling released before startup_done
// R22 - startup_done passes two flip-flops before use
`timescale 1ns/1ns
`default_nettype none
module module_reset_after_reconfig
  import module_reset_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // configuration engine
  input  wire logic              startup_done,
  // reset-less block isolation
  input  wire logic [DATA_W-1:0] noreset_in,
  input  wire logic [DATA_W-1:0] noreset_result,
  // resets and enables toward module logic
  output logic                   module_reset_out,
  output logic                   edge_reset_out,
  output logic                   init_rewrite,
  output logic                   noreset_clk_en,
  output logic [DATA_W-1:0]      noreset_in_gated,
  output logic [DATA_W-1:0]      noreset_out_gated,
  output logic                   running
);

  if (DATA_W < 1) begin : g_bad_width
    $error("DATA_W must be at least 1");
  end

  logic [SYNC_STAGES-1:0] done_sync;
  logic                   done_s;
  logic                   armed;
  logic                   next_armed;
  logic                   run_state;
  logic                   next_run_state;
  logic [1:0]             pulse_cnt;
  logic [1:0]             next_pulse_cnt;
  logic                   next_module_reset_out;
  logic                   next_edge_reset_out;
  logic                   next_init_rewrite;
  logic                   next_noreset_clk_en;
  logic [DATA_W-1:0]      next_noreset_in_gated;
  logic [DATA_W-1:0]      next_noreset_out_gated;

  // edge pulse counter still counting
  function automatic logic pulse_active(input logic [1:0] cnt);
    return cnt != PULSE_IDLE;
  endfunction

  // two-stage synchroniser; only stage 2 is read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      // presets as high so a level held through reset never arms
      done_sync <= {SYNC_STAGES{DONE_SYNC_RST}}; // R10
    end else begin
      done_sync <= {done_sync[SYNC_STAGES-2:0], startup_done}; // R22
    end
  end
  assign done_s = done_sync[SYNC_STAGES-1];

  // arming: startup_done is only trusted after it was seen low since reset/load
  always_comb begin
    next_armed = armed | ~done_s; // R9 R10
  end

  // single state bit: 0 await startup, 1 running
  always_comb begin
    next_run_state = run_state | (armed & done_s); // R7 R9 R10 R11
  end

  // edge pulse shaped so its end meets release of the level reset
  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (!run_state && armed && done_s) begin
      next_pulse_cnt = 2'(EDGE_PULSE_LEN); // R15
    end else if (pulse_cnt != PULSE_IDLE) begin
      next_pulse_cnt = pulse_cnt - 2'h1;
    end
  end

  always_comb begin
    next_module_reset_out  = ~next_run_state | pulse_active(next_pulse_cnt); // R7 R13 R16
    next_edge_reset_out    = pulse_active(next_pulse_cnt); // R15 R14
    next_init_rewrite      = run_state ^ next_run_state; // R12
    next_noreset_clk_en    = next_run_state; // R17 R21
    next_noreset_in_gated  = next_run_state ? noreset_in : '0; // R18
    next_noreset_out_gated = next_run_state ? noreset_result : '0; // R18 R14
  end

  // return to await-startup only by flip-flop reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      armed             <= STATE_RESET; // R8
      run_state         <= STATE_RESET; // R8
      pulse_cnt         <= PULSE_CNT_RST;
      module_reset_out  <= RESET_ACTIVE; // R5 R13
      edge_reset_out    <= ~RESET_ACTIVE;
      init_rewrite      <= 1'b0;
      noreset_clk_en    <= 1'b0;
      noreset_in_gated  <= '0;
      noreset_out_gated <= '0;
      running           <= 1'b0;
    end else begin
      armed             <= next_armed;
      run_state         <= next_run_state;
      pulse_cnt         <= next_pulse_cnt;
      module_reset_out  <= next_module_reset_out;
      edge_reset_out    <= next_edge_reset_out;
      init_rewrite      <= next_init_rewrite;
      noreset_clk_en    <= next_noreset_clk_en;
      noreset_in_gated  <= next_noreset_in_gated;
      noreset_out_gated <= next_noreset_out_gated;
      running           <= next_run_state;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_reset_while_await: assert property (!run_state |-> module_reset_out) // R7
    else $error("module reset low while awaiting startup");
  a_no_early_run: assert property ($rose(run_state) |-> $past(armed) && $past(done_s)) // R9
    else $error("ran without armed startup_done");
  a_stay_running: assert property (run_state |=> run_state) // R8
    else $error("state left running without reset");
  a_ignore_stuck_done: assert property (!armed |=> !run_state) // R10
    else $error("ran on startup_done held from reset");
  a_edge_then_release: assert property ($rose(run_state) |-> edge_reset_out ##1 edge_reset_out
                                        ##1 (!edge_reset_out && !module_reset_out)) // R15
    else $error("edge pulse not aligned with release");
  a_release_timing: assert property ($rose(run_state) |-> ##2 !module_reset_out) // R16
    else $error("module reset not released two cycles after run");
  a_clock_gate_hold: assert property (!running |-> !noreset_clk_en && noreset_out_gated == '0) // R17
    else $error("reset-less block enabled before startup");
  a_rewrite_pulse: assert property ($rose(run_state) |-> init_rewrite ##1 !init_rewrite) // R12
    else $error("rewrite pulse missing");
  a_rewrite_single: assert property (init_rewrite |=> !init_rewrite) // R12
    else $error("rewrite pulse longer than one cycle");
  a_rewrite_in_reset: assert property (init_rewrite |-> running && module_reset_out) // R12 R13
    else $error("rewrite pulse outside held reset");
  a_in_gate_hold: assert property (!running |-> noreset_in_gated == '0) // R18
    else $error("reset-less block input not forced safe");
  a_in_gate_pass: assert property (run_state |=> noreset_in_gated == $past(noreset_in)) // R18
    else $error("reset-less block input not passed when running");
  a_out_gate_pass: assert property (run_state |=> noreset_out_gated == $past(noreset_result)) // R18
    else $error("reset-less block output not passed when running");
  a_clk_en_match: assert property (noreset_clk_en == running) // R17 R21
    else $error("clock enable differs from running state");
  a_running_copy: assert property (running == run_state) // R7
    else $error("running output differs from state bit");
  a_edge_in_reset: assert property (edge_reset_out |-> module_reset_out) // R15
    else $error("edge pulse outside level reset");
  a_edge_low_await: assert property (!run_state |-> !edge_reset_out) // R14
    else $error("edge pulse before startup seen");
  a_edge_len: assert property ($rose(edge_reset_out) |=> edge_reset_out ##1 !edge_reset_out) // R15
    else $error("edge pulse length wrong");
  a_release_on_fall: assert property ($fell(edge_reset_out) |-> !module_reset_out) // R15
    else $error("level reset not released with edge pulse end");
  a_release_running: assert property ($fell(module_reset_out) |-> running) // R21
    else $error("module reset released before running");
  a_unarmed_idle: assert property (!armed |-> !run_state) // R9
    else $error("running without being armed");
  a_armed_stays: assert property (armed |=> armed) // R8
    else $error("arming lost without reset");
  a_sync_stage: assert property (done_s == $past(done_sync[0])) // R22
    else $error("synchroniser stage skipped");
  a_sync_path: assert property ($rose(startup_done) && armed |-> ##[1:3] run_state) // R22
    else $error("startup_done not acted on in sync time");

  c_run_entered: cover property ($rose(run_state));
  c_arm_then_run: cover property (!armed ##1 armed ##[1:10] run_state);
  c_edge_pulse: cover property ($rose(edge_reset_out) ##2 !edge_reset_out);
  c_stuck_done: cover property (!armed && done_s);
  c_rewrite: cover property (init_rewrite);

endmodule
`default_nettype wire

// ===== hdl/module_reset_pkg.sv
// constants for the swappable-module reset sequencer
package module_reset_pkg;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned EDGE_PULSE_LEN = 2;
  localparam logic        RESET_ACTIVE   = 1'b1;
  localparam logic        STATE_RESET    = 1'b0;
  localparam logic        DONE_SYNC_RST  = 1'b1;
  localparam logic [1:0]  PULSE_IDLE     = 2'h0;
  localparam logic [1:0]  PULSE_CNT_RST  = 2'h0;
endpackage

// ===== verification/shell_model.sv
// shell and configuration engine model driving the module reset and startup done
`timescale 1ns/1ns
`default_nettype none
module shell_model #(
  parameter int unsigned LOAD_CYCLES = 6
) (
  // clock and shell controls
  input  wire logic mclk,
  input  wire logic sys_rst_b,
  input  wire logic load_req,
  // toward the module
  output logic      rst_b,
  output var logic  startup_done
);
  int unsigned cnt = 0;
  initial startup_done = 1'b0;
  initial rst_b = 1'b0;
  // registered active-low combination of system reset and load request
  always @(posedge mclk) rst_b <= sys_rst_b & ~load_req;
  always @(posedge mclk) begin
    if (load_req) begin
      cnt <= 0;
      startup_done <= 1'b0;
    end else if (cnt < LOAD_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      startup_done <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/module_reset_after_reconfig_bench.sv
// bench for the swappable-module reset sequencer
`timescale 1ns/1ns
`default_nettype none
module module_reset_after_reconfig_bench
  import module_reset_pkg::*;
;
  logic       mclk = 1'b0, sys_rst_b = 1'b0, load_req = 1'b0, rst_b, startup_done;
  logic [7:0] ni = 8'h00, nr = 8'h00, nig, nog;
  logic       mro, ero, irw, cke, run;
  logic [7:0] row_in  [3] = '{8'h5A, 8'hFF, 8'h01};
  logic [7:0] row_res [3] = '{8'hC3, 8'h00, 8'h80};
  int         n_errors = 0, n_tests = 0;
  always #5 mclk = ~mclk;
  shell_model u_shell (.mclk(mclk), .sys_rst_b(sys_rst_b), .load_req(load_req),
    .rst_b(rst_b), .startup_done(startup_done));
  module_reset_after_reconfig u_dut (.mclk(mclk), .rst_b(rst_b), .startup_done(startup_done),
    .noreset_in(ni), .noreset_result(nr), .module_reset_out(mro), .edge_reset_out(ero),
    .init_rewrite(irw), .noreset_clk_en(cke), .noreset_in_gated(nig),
    .noreset_out_gated(nog), .running(run));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // waits for run entry, then follows the reset pulse sequence
  task automatic await_run();
    int i;
    for (i = 0; i < 50 && run !== 1'b1; i++) begin
      check("held", {nig | nog, cke, mro}, 16'h0001);
      @(posedge mclk);
      #1;
    end
    check("pulse 1", {run, mro, ero, irw}, 16'hF);
    @(posedge mclk);
    #1 check("pulse 2", {run, mro, ero, irw}, 16'hE);
    @(posedge mclk);
    #1 check("pulse 3", {run, cke, mro, ero, irw}, 16'h18);
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst_b <= 1'b1;
    #1 await_run();
    foreach (row_in[k]) begin
      @(posedge mclk);
      ni <= row_in[k];
      nr <= row_res[k];
      @(posedge mclk);
      #1 check("in gated", nig, row_in[k]);
      check("out gated", nog, row_res[k]);
    end
    @(posedge mclk);
    sys_rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    sys_rst_b <= 1'b1;
    repeat (12) @(posedge mclk);
    #1 check("stale done", {run, cke, mro}, 16'h1);
    @(posedge mclk);
    load_req <= 1'b1;
    repeat (2) @(posedge mclk);
    load_req <= 1'b0;
    #1 await_run();
    complete_run();
  end
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
